/* dv/tb.sv */
// self-checking bench for the clock stop and watchdog block
`timescale 1ns/100ps
`include "wdt_defs.svh"
module tb;
   // --------------------
   // signals
   // --------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic tu_run;
   logic ub_run;
   logic ub_stopped;
   logic por_req;
   logic man_req;
   logic irq;
   logic [31:0] rdata_v;
   logic err_v;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int por_n = 0;
   int man_n = 0;

   always #10 pclk = ~pclk;

   clock_stop_watchdog uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .timer_unit_clock_run(tu_run),
      .user_break_clock_run(ub_run), .user_break_stopped(ub_stopped),
      .wdt_poweron_reset_req(por_req), .wdt_manual_reset_req(man_req), .irq(irq));

   // the sweep of the slowest select needs about 20k cycles, the rest a few hundred
   always @(posedge pclk) begin
      cycles++;
      if (por_req === 1'b1) por_n++;
      if (man_req === 1'b1) man_n++;
      if (cycles == 40000) begin
         bad_count++;
         wrap_up();
      end
   end

   // --------------------
   // helpers
   // --------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // request held until pready is seen high at a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) check("pready", 0, 1);
      rdata_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      xfer(a, 1'b1, d, s);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      xfer(a, 1'b0, 32'h0000_0000, 4'h0);
   endtask : rd

   task automatic wcnt(input logic [7:0] v);
      wr(`OFS_COUNT, {16'h0000, `KEY_COUNT, v}, `STRB_HALF);
   endtask : wcnt

   task automatic wcsr(input logic [7:0] v);
      wr(`OFS_CSR, {16'h0000, `KEY_CSR, v}, `STRB_HALF);
   endtask : wcsr

   // --------------------
   // tests
   // --------------------
   task automatic t_reset();
      check("tu_run_rst", tu_run, 1);
      check("ub_run_rst", ub_run, 1);
      check("ub_stopped_rst", ub_stopped, 0);
      rd(`OFS_COUNT);
      check("count_rst", rdata_v <= 32'd4, 1);
      rd(`OFS_CSR);
      check("csr_rst", rdata_v, 0);
      rd(`OFS_IRQ_STATUS);
      check("status_rst", rdata_v, 0);
      rd(8'h40);
      check("unmapped_err", err_v, 1);
      check("unmapped_data", rdata_v, 0);
      $display("test reset done");
   endtask : t_reset

   // slowest select first, so the count holds still while keys are tried
   task automatic t_keys();
      wcsr(8'h07);
      wr(`OFS_CTRL_SECOND, 32'h0000_0001, `STRB_BYTE0);
      wcnt(8'h33);
      rd(`OFS_COUNT);
      check("count_key", rdata_v >= 32'h33 && rdata_v <= 32'h34, 1);
      wr(`OFS_COUNT, 32'h0000_a577, `STRB_HALF);
      rd(`OFS_COUNT);
      check("count_badkey", rdata_v >= 32'h33 && rdata_v <= 32'h35, 1);
      wr(`OFS_COUNT, 32'h0000_5a77, `STRB_BYTE0);
      rd(`OFS_COUNT);
      check("count_badwidth", rdata_v >= 32'h33 && rdata_v <= 32'h35, 1);
      wr(`OFS_CSR, 32'h0000_5a47, `STRB_HALF);
      rd(`OFS_CSR);
      check("csr_badkey", rdata_v, 32'h07);
      wr(`OFS_CSR, 32'h0000_a547, 4'b1111);
      rd(`OFS_CSR);
      check("csr_badwidth", rdata_v, 32'h07);
      wcsr(8'h27);
      rd(`OFS_CSR);
      check("csr_key", rdata_v, 32'h27);
      wcsr(8'h07);
      $display("test keys done");
   endtask : t_keys

   task automatic t_stop();
      wr(`OFS_STOP_CTRL, 32'h0000_0004, `STRB_BYTE0);
      repeat (2) @(posedge pclk);
      check("tu_run_off", tu_run, 0);
      rd(`OFS_STOP_CTRL);
      check("stop_ctrl_rd", rdata_v, 32'h04);
      wr(`OFS_STOP_CTRL, 32'h0000_0000, `STRB_BYTE0);
      repeat (2) @(posedge pclk);
      check("tu_run_on", tu_run, 1);
      // nothing else writes stop registers
      // stop sequence: read-modify-write then two reads
      rd(`OFS_STOP_CTRL_SECOND);
      wr(`OFS_STOP_CTRL_SECOND, rdata_v | 32'h0000_0001, `STRB_BYTE0);
      rd(`OFS_STOP_CTRL_SECOND);
      rd(`OFS_STOP_CTRL_SECOND);
      check("ub_stop_rd", rdata_v, 32'h01);
      check("ub_run_off", ub_run, 0);
      check("ub_stopped_on", ub_stopped, 1);
      rd(`OFS_STOP_CTRL_SECOND);
      wr(`OFS_STOP_CTRL_SECOND, rdata_v & 32'hffff_fffe, `STRB_BYTE0);
      rd(`OFS_STOP_CTRL_SECOND);
      rd(`OFS_STOP_CTRL_SECOND);
      check("ub_run_back", ub_run, 1);
      check("ub_stopped_off", ub_stopped, 0);
      $display("test stop done");
   endtask : t_stop

   // tolerance covers the unknown prescaler phase and read latency
   task automatic t_rate();
      logic [3:0] s;
      int div;
      for (int i = 0; i < 3; i++) begin
         s = (i == 0) ? 4'h0 : (i == 1) ? 4'h2 : 4'h8;
         div = 2 << s;
         wr(`OFS_CTRL_SECOND, {31'h0, s[3]}, `STRB_BYTE0);
         wcsr({5'h00, s[2:0]});
         wcnt(8'h00);
         repeat (40 * div) @(posedge pclk);
         rd(`OFS_COUNT);
         check("count_rate", rdata_v >= 32'd39 && rdata_v <= 32'd43, 1);
      end
      $display("test rate done");
   endtask : t_rate

   task automatic t_irq();
      int p0;
      p0 = por_n + man_n;
      wr(`OFS_IRQ_MASK, 32'h0000_0000, `STRB_BYTE0);
      wr(`OFS_CTRL_SECOND, 32'h0000_0000, `STRB_BYTE0);
      wcsr(8'h00);
      wcnt(8'hf0);
      repeat (40) @(posedge pclk);
      check("irq_masked", irq, 0);
      rd(`OFS_IRQ_STATUS);
      check("status_iv", rdata_v, 32'h01);
      rd(`OFS_CSR);
      check("csr_iv_flags", rdata_v & 32'h18, 32'h08);
      wr(`OFS_IRQ_MASK, 32'h0000_0001, `STRB_BYTE0);
      repeat (2) @(posedge pclk);
      check("irq_on", irq, 1);
      wr(`OFS_IRQ_STATUS, 32'h0000_0001, `STRB_BYTE0);
      repeat (2) @(posedge pclk);
      check("irq_off", irq, 0);
      rd(`OFS_IRQ_STATUS);
      check("status_clr", rdata_v, 0);
      // second overflow with the mask open drives the line
      wcnt(8'hf0);
      repeat (40) @(posedge pclk);
      check("irq_unmasked", irq, 1);
      wr(`OFS_IRQ_STATUS, 32'h0000_0001, `STRB_BYTE0);
      repeat (2) @(posedge pclk);
      check("irq_off_again", irq, 0);
      check("no_reset_iv", por_n + man_n - p0, 0);
      $display("test irq done");
   endtask : t_irq

   task automatic t_wdog();
      int p0;
      int m0;
      for (int j = 0; j < 2; j++) begin
         // clear the old event so each pass must set it anew
         wr(`OFS_IRQ_STATUS, 32'h0000_0002, `STRB_BYTE0);
         p0 = por_n;
         m0 = man_n;
         wcsr(j == 0 ? 8'h40 : 8'h60);
         wcnt(8'hf0);
         repeat (40) @(posedge pclk);
         check("por_pulses", por_n - p0, j == 0 ? 1 : 0);
         check("man_pulses", man_n - m0, j == 0 ? 0 : 1);
         rd(`OFS_CSR);
         check("csr_wd_kept", rdata_v & 32'h70, j == 0 ? 32'h50 : 32'h70);
         rd(`OFS_IRQ_STATUS);
         check("status_wd", rdata_v & 32'h02, 32'h02);
      end
      // back to a slow interval setting so nothing fires late
      wcsr(8'h07);
      wr(`OFS_CTRL_SECOND, 32'h0000_0001, `STRB_BYTE0);
      $display("test watchdog done");
   endtask : t_wdog

   // --------------------
   // main
   // --------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_keys();
      t_stop();
      t_rate();
      t_irq();
      t_wdog();
      wrap_up();
   end
endmodule : tb

/* include/wdt_defs.svh */
// register offsets, field positions, keys and reset values of the clock stop and watchdog block
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_STOP_CTRL 8'h04
`define OFS_COUNT 8'h08
`define OFS_CSR 8'h0c
`define OFS_STOP_CTRL_SECOND 8'h10
`define OFS_CTRL_SECOND 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1c

// ------------------------------------------------------------
// write keys and access shape
// ------------------------------------------------------------
`define KEY_COUNT 8'h5a
`define KEY_CSR 8'ha5
`define STRB_HALF 4'b0011
`define STRB_BYTE0 4'b0001

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_TU_STOP 2
`define BIT_UB_STOP 0
`define BIT_INTERVAL_OVERFLOW_FLAG 3
`define BIT_WATCHDOG_OVERFLOW_FLAG 4
`define BIT_RSTS 5
`define BIT_MODE 6
`define BIT_CKS_HIGH 0
`define EV_INTERVAL_OVERFLOW_FLAG 0
`define EV_WATCHDOG_OVERFLOW_FLAG 1

// ------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define MASK_STOP_CTRL 8'h04
`define MASK_STOP_CTRL_SECOND 8'h01
`define MASK_CSR_SW 8'hf7
`define COUNT_MAX 8'hff

`endif

/* include/wdt_pkg.sv */
// types shared by the clock stop and watchdog block
package wdt_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } apb_state_e;

   typedef struct packed {
      apb_state_e st;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] stop_ctrl;
      logic [7:0] stop_ctrl_second;
      logic [7:0] count;
      logic [7:0] csr;
      logic [7:0] ctrl_second;
      logic rst_poweron;
      logic rst_manual;
      logic tu_run;
      logic ub_run;
   } main_state_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } presc_state_s;

   typedef struct packed {
      logic [1:0] status;
      logic [1:0] mask;
      logic irq;
   } flags_state_s;

endpackage : wdt_pkg

/* rtl/clock_stop_watchdog.sv */
// module clock stop control and watchdog/interval timer behind an apb slave
//
// Function
// - timer unit stop bit gates its clock
// - gated timer unit keeps its state
// - break unit stop bit gates, stops unit
// - stopped break register accesses are unspecified
// - clearing break stop bit restarts clock
// - eight bit up counter on count clock
// - overflow gives reset or interrupt by mode
// - counter cleared only by power-on reset
// - counter write needs half word, key 5a
// - counter and status read back current value
// - status register survives watchdog internal reset
// - status write needs half word, key a5
// - four select bits pick sixteen divisions
// - mode bit zero interval, one watchdog
// - overflow flag set matches current mode
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "wdt_defs.svh"
module clock_stop_watchdog (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic timer_unit_clock_run,
   output logic user_break_clock_run,
   output logic user_break_stopped,
   output logic wdt_poweron_reset_req,
   output logic wdt_manual_reset_req,
   output logic irq
);
   wdt_pkg::main_state_s s_q, s_d;

   logic tick;
   logic [1:0] ev_set;
   logic [1:0] ev_status;
   logic [1:0] ev_mask;
   logic ev_irq;
   logic xfer;
   logic wr;
   logic rd;
   logic cnt_wr_ok;
   logic csr_wr_ok;
   logic ovf;
   logic [3:0] clk_sel;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction : hit

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, `OFS_STOP_CTRL) | hit(a, `OFS_COUNT) | hit(a, `OFS_CSR) |
               hit(a, `OFS_STOP_CTRL_SECOND) | hit(a, `OFS_CTRL_SECOND) |
               hit(a, `OFS_IRQ_STATUS) | hit(a, `OFS_IRQ_MASK);
   endfunction : mapped

   function automatic logic keyed(input logic [3:0] strb, input logic [31:0] d, input logic [7:0] key);
      keyed = (strb == `STRB_HALF) & (d[15:8] == key);
   endfunction : keyed

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // the transfer completes at the edge where our registered pready is seen high
   assign xfer = psel & penable & (s_q.st == wdt_pkg::ST_DONE);
   assign wr = xfer & pwrite & mapped(paddr);
   assign rd = psel & penable & ~pwrite & (s_q.st == wdt_pkg::ST_IDLE);

   // bad key or width drops write
   assign cnt_wr_ok = wr & hit(paddr, `OFS_COUNT) & keyed(pstrb, pwdata, `KEY_COUNT);
   assign csr_wr_ok = wr & hit(paddr, `OFS_CSR) & keyed(pstrb, pwdata, `KEY_CSR);

   assign clk_sel = {s_q.ctrl_second[`BIT_CKS_HIGH], s_q.csr[2:0]};

   // a write in the same cycle replaces the count, so no overflow is taken then
   assign ovf = tick & ~cnt_wr_ok & (s_q.count == `COUNT_MAX);

   assign ev_set[`EV_INTERVAL_OVERFLOW_FLAG] = ovf & ~s_q.csr[`BIT_MODE];
   assign ev_set[`EV_WATCHDOG_OVERFLOW_FLAG] = ovf & s_q.csr[`BIT_MODE];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rst_poweron = 1'b0;
      s_d.rst_manual = 1'b0;

      case (s_q.st)
         wdt_pkg::ST_IDLE: begin
            s_d.pready = 1'b0;
            if (psel & penable) begin
               s_d.st = wdt_pkg::ST_DONE;
               s_d.pready = 1'b1;
               s_d.pslverr = ~mapped(paddr);
               s_d.prdata = `RST_WORD;
               if (rd) begin
                  if (hit(paddr, `OFS_STOP_CTRL)) begin
                     s_d.prdata = {24'h00_0000, s_q.stop_ctrl};
                  end else if (hit(paddr, `OFS_COUNT)) begin
                     s_d.prdata = {24'h00_0000, s_q.count};
                  end else if (hit(paddr, `OFS_CSR)) begin
                     s_d.prdata = {24'h00_0000, s_q.csr};
                  end else if (hit(paddr, `OFS_STOP_CTRL_SECOND)) begin
                     s_d.prdata = {24'h00_0000, s_q.stop_ctrl_second};
                  end else if (hit(paddr, `OFS_CTRL_SECOND)) begin
                     s_d.prdata = {24'h00_0000, s_q.ctrl_second};
                  end else if (hit(paddr, `OFS_IRQ_STATUS)) begin
                     s_d.prdata = {30'h0000_0000, ev_status};
                  end else if (hit(paddr, `OFS_IRQ_MASK)) begin
                     s_d.prdata = {30'h0000_0000, ev_mask};
                  end
               end
            end
         end
         wdt_pkg::ST_DONE: begin
            s_d.st = wdt_pkg::ST_IDLE;
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            // data zeroed after the answer so a stale read never lingers
            s_d.prdata = `RST_WORD;
         end
         default: begin
            s_d.st = wdt_pkg::ST_IDLE;
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            s_d.prdata = `RST_WORD;
         end
      endcase

      if (wr & hit(paddr, `OFS_STOP_CTRL) & pstrb[0]) begin
         s_d.stop_ctrl = pwdata[7:0] & `MASK_STOP_CTRL;
      end
      // break unit stop bit, cleared to restart
      if (wr & hit(paddr, `OFS_STOP_CTRL_SECOND) & pstrb[0]) begin
         s_d.stop_ctrl_second = pwdata[7:0] & `MASK_STOP_CTRL_SECOND;
      end
      if (wr & hit(paddr, `OFS_CTRL_SECOND) & pstrb[0]) begin
         s_d.ctrl_second = {7'h00, pwdata[`BIT_CKS_HIGH]};
      end
      // run flags kept in flops so the gate enables leave no logic behind them
      s_d.tu_run = ~s_d.stop_ctrl[`BIT_TU_STOP];
      s_d.ub_run = ~s_d.stop_ctrl_second[`BIT_UB_STOP];

      if (cnt_wr_ok) begin
         s_d.count = pwdata[7:0];
      end else if (tick) begin
         s_d.count = s_q.count + 8'h01;
      end

      // keyed status write, interval flag only readable
      if (csr_wr_ok) begin
         s_d.csr = (pwdata[7:0] & `MASK_CSR_SW) | (s_q.csr & ~`MASK_CSR_SW);
      end
      // flag set follows mode, set beats write
      if (ev_set[`EV_INTERVAL_OVERFLOW_FLAG]) begin
         s_d.csr[`BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
      end
      if (ev_set[`EV_WATCHDOG_OVERFLOW_FLAG]) begin
         s_d.csr[`BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
         s_d.rst_poweron = ~s_q.csr[`BIT_RSTS];
         s_d.rst_manual = s_q.csr[`BIT_RSTS];
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // only the power-on reset clears count, and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.st <= wdt_pkg::ST_IDLE;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.prdata <= `RST_WORD;
         s_q.stop_ctrl <= `RST_BYTE;
         s_q.stop_ctrl_second <= `RST_BYTE;
         s_q.count <= `RST_BYTE;
         s_q.csr <= `RST_BYTE;
         s_q.ctrl_second <= `RST_BYTE;
         s_q.rst_poweron <= 1'b0;
         s_q.rst_manual <= 1'b0;
         s_q.tu_run <= 1'b1;
         s_q.ub_run <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // children
   // ------------------------------------------------------------
   // the divider never stops, so a stopped count only loses its phase, not its value
   wdt_prescaler u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .sel(clk_sel),
      .tick(tick)
   );

   wdt_event_flags #(.N(2)) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set_ev(ev_set),
      .clr_we(wr & hit(paddr, `OFS_IRQ_STATUS) & pstrb[0]),
      .clr_data(pwdata[1:0]),
      .mask_we(wr & hit(paddr, `OFS_IRQ_MASK) & pstrb[0]),
      .mask_data(pwdata[1:0]),
      .status(ev_status),
      .mask(ev_mask),
      .irq(ev_irq)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign prdata = s_q.prdata;
   // no edges reach the stopped timer unit, so it holds
   assign timer_unit_clock_run = s_q.tu_run;
   // break unit registers are left unspecified while stopped
   assign user_break_clock_run = s_q.ub_run;
   assign user_break_stopped = s_q.stop_ctrl_second[`BIT_UB_STOP];
   assign wdt_poweron_reset_req = s_q.rst_poweron;
   assign wdt_manual_reset_req = s_q.rst_manual;
   assign irq = ev_irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_tu_clock_stop: assert property (wr & hit(paddr, `OFS_STOP_CTRL) & pstrb[0] & pwdata[`BIT_TU_STOP]
      |=> !timer_unit_clock_run)
      else $error("timer unit clock still running after stop");

   // clock stays off with no write
   a_tu_clock_hold: assert property (!timer_unit_clock_run & !(wr & hit(paddr, `OFS_STOP_CTRL))
      |=> !timer_unit_clock_run)
      else $error("timer unit clock restarted on its own");

   // break unit stopped and gated together
   a_ub_stop: assert property (wr & hit(paddr, `OFS_STOP_CTRL_SECOND) & pstrb[0] & pwdata[`BIT_UB_STOP]
      |=> user_break_stopped & !user_break_clock_run)
      else $error("break unit not stopped");

   a_ub_restart: assert property (wr & hit(paddr, `OFS_STOP_CTRL_SECOND) & pstrb[0] & !pwdata[`BIT_UB_STOP]
      |=> user_break_clock_run & !user_break_stopped)
      else $error("break unit clock not restarted");

   a_count_step: assert property (tick & !cnt_wr_ok |=> s_q.count == $past(s_q.count) + 8'h01)
      else $error("counter did not step on tick");

   a_ovf_reset: assert property (ovf & s_q.csr[`BIT_MODE]
      |=> (wdt_poweron_reset_req ^ wdt_manual_reset_req) ##1 !wdt_poweron_reset_req & !wdt_manual_reset_req)
      else $error("watchdog overflow gave no single reset pulse");

   a_ovf_irq: assert property (ovf & !s_q.csr[`BIT_MODE] & ev_mask[`EV_INTERVAL_OVERFLOW_FLAG]
      & !(wr & hit(paddr, `OFS_IRQ_MASK)) |-> ##1 irq)
      else $error("interval overflow gave no interrupt");

   a_mode_no_reset: assert property (ovf & !s_q.csr[`BIT_MODE] |=> !wdt_poweron_reset_req & !wdt_manual_reset_req)
      else $error("reset requested in interval mode");

   a_flag_mode: assert property (ovf |=> ($past(s_q.csr[`BIT_MODE])
      ? (s_q.csr[`BIT_WATCHDOG_OVERFLOW_FLAG] && $stable(s_q.csr[`BIT_INTERVAL_OVERFLOW_FLAG])) : s_q.csr[`BIT_INTERVAL_OVERFLOW_FLAG]))
      else $error("overflow flag does not match mode");

   a_key_reject: assert property (wr & hit(paddr, `OFS_COUNT) & !cnt_wr_ok & !tick |=> $stable(s_q.count))
      else $error("counter changed on a bad write");

   a_count_load: assert property (cnt_wr_ok |=> s_q.count == $past(pwdata[7:0]))
      else $error("counter not loaded by keyed write");

   // read data answers one cycle into access
   a_read_back: assert property (rd & hit(paddr, `OFS_COUNT) |=> pready && prdata[7:0] == $past(s_q.count))
      else $error("counter read back wrong");

   a_csr_read: assert property (rd & hit(paddr, `OFS_CSR) |=> pready && prdata[7:0] == $past(s_q.csr))
      else $error("status register read back wrong");

   a_csr_key_reject: assert property (wr & hit(paddr, `OFS_CSR) & !csr_wr_ok & !ovf |=> $stable(s_q.csr))
      else $error("status register changed on a bad write");

   a_csr_load: assert property (csr_wr_ok & !ovf
      |=> s_q.csr[7:4] == $past(pwdata[7:4]) && s_q.csr[2:0] == $past(pwdata[2:0]))
      else $error("status register not loaded by keyed write");

   // interval flag only set by overflow
   a_interval_overflow_flag_read_only: assert property (csr_wr_ok & !ovf |=> $stable(s_q.csr[`BIT_INTERVAL_OVERFLOW_FLAG]))
      else $error("interval flag changed by a write");

   // count moves only by tick or write
   a_count_hold: assert property (!tick & !cnt_wr_ok |=> $stable(s_q.count))
      else $error("counter changed with no tick and no write");

   a_count_wrap: assert property (tick & !cnt_wr_ok & (s_q.count == `COUNT_MAX) |=> s_q.count == 8'h00)
      else $error("counter did not wrap on overflow");
endmodule : clock_stop_watchdog

/* rtl/wdt_event_flags.sv */
// sticky event flags with write-one-to-clear, a mask and one level interrupt
`timescale 1ns/100ps
module wdt_event_flags #(
   parameter int N = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] set_ev,
   input wire logic clr_we,
   input wire logic [N-1:0] clr_data,
   input wire logic mask_we,
   input wire logic [N-1:0] mask_data,
   output logic [N-1:0] status,
   output logic [N-1:0] mask,
   output logic irq
);
   wdt_pkg::flags_state_s s_q, s_d;

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (clr_we) begin
         s_d.status = s_q.status & ~clr_data;
      end
      // a new event beats a clear in the same cycle
      s_d.status = s_d.status | set_ev;
      if (mask_we) begin
         s_d.mask = mask_data;
      end
      s_d.irq = |(s_d.status & s_d.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign status = s_q.status;
   assign mask = s_q.mask;
   assign irq = s_q.irq;
endmodule : wdt_event_flags

/* rtl/wdt_prescaler.sv */
// free-running divider that yields one count tick per selected division of pclk
`timescale 1ns/100ps
module wdt_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] sel,
   output logic tick
);
   wdt_pkg::presc_state_s s_q, s_d;

   function automatic logic pick(input logic [15:0] c, input logic [3:0] k);
      pick = c[k];
   endfunction : pick

   // ------------------------------------------------------------
   // divider
   // ------------------------------------------------------------
   // a select change may give one short period; software should clear the count after it
   always_comb begin
      s_d = s_q;
      s_d.cnt = s_q.cnt + 16'h0001;
      s_d.tick = pick(s_d.cnt, sel) & ~pick(s_q.cnt, sel);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule : wdt_prescaler
